// file: hw/rssm_top.sv
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
// How it works
// - Pin, low voltage, watchdog start one sequence.
// - Illegal opcode or prebyte also starts reset.
// - Reset pin driven low during delay.
// - Vector fetched from top two addresses.
// - Phases run active, delay, then fetch.
// - Delay 256 cycles, 4096 with crystal.
// - Vector fetch lasts exactly two cycles.
// - PLL start-up wait added when enabled.
// - Pin low detected without the clock.
// - Pin is input plus open-drain output.
// - Low supply holds pin low throughout.
// - Watchdog underflow drives pin minimum pulse.
// - Low voltage detector optional, three levels.
// - Live aux flag readable, never latched.
// - Aux detector works only with detector enabled.
// - Aux threshold follows detector level setting.
// - Aux flag rise requests enabled unmasked interrupt.
// - Aux interrupt wakes wait, never halt.
// - Halt freezes status register except on reset events, detector runs.
// - Bit 7 mirrors fast PLL lock.
// - Watchdog flag set by watchdog, cleared by low voltage or write.
// - Low voltage flag cleared only by read.
// - Pending aux interrupt cleared on service entry.
// - Bit 3 mirrors main PLL lock.
module rssm_top
  import rssm_pkg::*;
#(
  parameter int unsigned PLL_STARTUP_NS = 1000,
  parameter int unsigned WDG_PULSE_NS   = 200
)
(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RSTN,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  // Reset pin
  input  wire logic        RESET_PIN_I,
  output logic             RESET_PIN_O,
  output logic             RESET_PIN_OE,
  // Reset sources
  input  wire logic        LV_BELOW_I,
  input  wire logic        WDG_UNDERFLOW_I,
  input  wire logic        ILLEGAL_OPCODE_I,
  // Configuration
  input  wire logic        LV_ENABLE_I,
  input  wire logic [1:0]  LV_LEVEL_I,
  input  wire logic        CLK_SRC_CRYSTAL_I,
  input  wire logic        PLL_ENABLE_I,
  // Analog and clock status
  input  wire logic        AUX_BELOW_I,
  input  wire logic        PLL_LOCKED_I,
  input  wire logic        FAST_PLL_LOCKED_I,
  // Core status
  input  wire logic        HALT_MODE_I,
  input  wire logic        WAIT_MODE_I,
  input  wire logic        CORE_IRQ_MASK_I,
  input  wire logic        AUX_IRQ_ENTRY_I,
  // Core side outputs
  output logic             CORE_RESET_N,
  output logic             VECTOR_FETCH,
  output logic [15:0]      VECTOR_ADDR,
  output logic             AUX_IRQ,
  output logic             WAKE_REQ,
  // Detector configuration
  output logic             DETECT_ENABLE,
  output logic [1:0]       DETECT_LEVEL
);

  localparam int unsigned PLL_CYCLES_RAW = (PLL_STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PLL_CYCLES     = (PLL_CYCLES_RAW < 1) ? 1 : PLL_CYCLES_RAW;
  localparam int unsigned WDG_CYCLES_RAW = (WDG_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WDG_CYCLES     = (WDG_CYCLES_RAW < 1) ? 1 : WDG_CYCLES_RAW;

  generate
    if (PLL_CYCLES >= (1 << CNT_W) || WDG_CYCLES >= (1 << CNT_W)) begin : g_count_check
      $error("rssm_top: start-up or pulse time exceeds the phase timer");
    end
  endgenerate

  rssm_state_t      state;
  rssm_state_t      next_state;
  logic             pin_level;
  logic             timer_done;
  logic             timer_load;
  logic [CNT_W-1:0] timer_value;
  logic             lv_request;
  logic             internal_pulse;
  logic             ext_clr_n;
  logic             bus_req;
  logic             bus_hit;
  logic             bus_write;
  logic             bus_read;
  logic             aux_live;
  logic             aux_prev;
  logic             aux_rise;
  logic             irq_pending;
  logic [1:0]       trim;
  logic             aux_irq_enable;
  logic             wdg_reset_flag;
  logic             lv_reset_flag;
  logic             aux_flag;
  logic             pll_locked;
  logic             fast_pll_locked;
  logic [7:0]       status_word;
  logic             halted;

  assign ext_clr_n = RSTN & RESET_PIN_I;

  rssm_pin_sync u_pin_sync (
    .clk   (MCLK),
    .clr_n (ext_clr_n),
    .level (pin_level)
  );

  rssm_phase_timer #(
    .WIDTH (CNT_W)
  ) u_timer (
    .clk        (MCLK),
    .rst_n      (RSTN),
    .load       (timer_load),
    .load_value (timer_value),
    .done       (timer_done)
  );

  assign lv_request     = LV_ENABLE_I & LV_BELOW_I;
  assign internal_pulse = WDG_UNDERFLOW_I | ILLEGAL_OPCODE_I;
  assign halted         = HALT_MODE_I;

  // Sequencer next state. The pin restarts the sequence from the run phase or an undriven active phase, a low supply from any phase;
  // a watchdog or opcode event is only taken while the core runs, since the core is held in reset otherwise.
  always_comb begin
    next_state  = state;
    timer_load  = 1'b0;
    timer_value = '0;
    case (state)
      SEQ_ACTIVE: begin
        if (pin_level && !lv_request && timer_done) begin
          next_state  = SEQ_DELAY;
          timer_load  = 1'b1;
          timer_value = CLK_SRC_CRYSTAL_I ? DELAY_LONG_CYCLES - 1'b1 : DELAY_SHORT_CYCLES - 1'b1;
        end
      end
      SEQ_DELAY: begin
        if (timer_done) begin
          if (PLL_ENABLE_I) begin
            next_state  = SEQ_PLL_WAIT;
            timer_load  = 1'b1;
            timer_value = CNT_W'(PLL_CYCLES - 1);
          end else begin
            next_state  = SEQ_FETCH;
            timer_load  = 1'b1;
            timer_value = FETCH_CYCLES - 1'b1;
          end
        end
      end
      SEQ_PLL_WAIT: begin
        if (timer_done) begin
          next_state  = SEQ_FETCH;
          timer_load  = 1'b1;
          timer_value = FETCH_CYCLES - 1'b1;
        end
      end
      SEQ_FETCH: begin
        if (timer_done) begin
          next_state = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (internal_pulse) begin
          next_state  = SEQ_ACTIVE;
          timer_load  = 1'b1;
          timer_value = CNT_W'(WDG_CYCLES - 1);
        end
      end
      default: begin
        next_state = SEQ_ACTIVE;
      end
    endcase
    // Our own drive reads back as a low pin; the pin counts only while undriven and outside the fetch.
    if ((!pin_level && !RESET_PIN_OE && state != SEQ_FETCH) || lv_request) begin
      next_state  = SEQ_ACTIVE;
      timer_load  = 1'b1;
      timer_value = '0;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= SEQ_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  // Pin drive and core reset. In the active phase we drive only for a low supply or an internal pulse, so that
  // an outside hold stays visible; releasing at the fetch start lets the synchroniser settle before the core runs.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      RESET_PIN_OE <= 1'b1;
      RESET_PIN_O  <= 1'b0;
      CORE_RESET_N <= 1'b0;
    end else begin
      RESET_PIN_O  <= 1'b0;
      RESET_PIN_OE <= (next_state == SEQ_DELAY) || (next_state == SEQ_PLL_WAIT) ||
                      (next_state == SEQ_ACTIVE && (lv_request || (state == SEQ_RUN && internal_pulse) ||
                                                   (state == SEQ_ACTIVE && !timer_done)));
      CORE_RESET_N <= (next_state == SEQ_RUN);
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      VECTOR_FETCH <= 1'b0;
      VECTOR_ADDR  <= 16'h0000;
    end else begin
      VECTOR_FETCH <= (next_state == SEQ_FETCH);
      if (next_state == SEQ_FETCH) begin
        VECTOR_ADDR <= (state == SEQ_FETCH) ? VECTOR_ADDR_HI : VECTOR_ADDR_LO;
      end else begin
        VECTOR_ADDR <= 16'h0000;
      end
    end
  end

  // Wishbone classic slave with one wait state. Unmapped addresses are acknowledged, read zero and drop writes.
  assign bus_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign bus_hit   = (WB_ADR_I == INTEG_OFFSET) & WB_SEL_I[0];
  assign bus_write = bus_req & bus_hit & WB_WE_I & ~halted;
  assign bus_read  = bus_req & bus_hit & ~WB_WE_I & ~halted;

  assign status_word = {fast_pll_locked, trim, wdg_reset_flag, pll_locked, lv_reset_flag, aux_flag, aux_irq_enable};

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= bus_req;
      if (bus_req && !WB_WE_I) begin
        WB_DAT_O <= bus_hit ? {24'h00_0000, status_word} : 32'h0000_0000;
      end
    end
  end

  // Software fields return to their reset values on every reset sequence; the flags survive it so that the
  // cause of the last reset can be read afterwards.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      trim           <= TRIM_RESET;
      aux_irq_enable <= INTEG_RESET[BIT_AUX_IRQ_ENABLE];
    end else if (!CORE_RESET_N) begin
      trim           <= TRIM_RESET;
      aux_irq_enable <= INTEG_RESET[BIT_AUX_IRQ_ENABLE];
    end else if (bus_write) begin
      trim           <= WB_DAT_I[BIT_TRIM_HIGH:BIT_TRIM_LOW];
      aux_irq_enable <= WB_DAT_I[BIT_AUX_IRQ_ENABLE];
    end
  end

  // A reset entry in the same cycle as a software clear wins.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      wdg_reset_flag <= INTEG_RESET[BIT_WDG_RESET_FLAG];
    end else if (lv_request) begin
      wdg_reset_flag <= 1'b0;
    end else if (state == SEQ_RUN && WDG_UNDERFLOW_I) begin
      wdg_reset_flag <= 1'b1;
    end else if (bus_write && !WB_DAT_I[BIT_WDG_RESET_FLAG]) begin
      wdg_reset_flag <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      lv_reset_flag <= INTEG_RESET[BIT_LV_RESET_FLAG];
    end else if (lv_request) begin
      lv_reset_flag <= 1'b1;
    end else if (bus_read) begin
      lv_reset_flag <= 1'b0;
    end
  end

  // Hardware status bits follow their sources, but hold still while halted.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      aux_flag        <= INTEG_RESET[BIT_AUX_FLAG];
      pll_locked      <= INTEG_RESET[BIT_PLL_LOCKED];
      fast_pll_locked <= INTEG_RESET[BIT_FAST_PLL_LOCKED];
    end else if (!halted) begin
      aux_flag        <= aux_live;
      pll_locked      <= PLL_LOCKED_I;
      fast_pll_locked <= FAST_PLL_LOCKED_I;
    end
  end

  // The comparator edge is tracked in halt too; only the register view and the request are frozen.
  assign aux_live = AUX_BELOW_I & LV_ENABLE_I;
  assign aux_rise = aux_live & ~aux_prev;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      aux_prev <= 1'b0;
    end else begin
      aux_prev <= aux_live;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_pending <= 1'b0;
    end else if (!CORE_RESET_N) begin
      irq_pending <= 1'b0;
    end else if (aux_rise && aux_irq_enable && !halted) begin
      irq_pending <= 1'b1;
    end else if (AUX_IRQ_ENTRY_I) begin
      irq_pending <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      AUX_IRQ  <= 1'b0;
      WAKE_REQ <= 1'b0;
    end else begin
      AUX_IRQ  <= irq_pending & ~CORE_IRQ_MASK_I & ~halted;
      WAKE_REQ <= irq_pending & WAIT_MODE_I & ~halted;
    end
  end

  // The aux threshold has no setting of its own; the analog side derives it from the detector level.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      DETECT_ENABLE <= 1'b0;
      DETECT_LEVEL  <= LEVEL_LOW;
    end else begin
      DETECT_ENABLE <= LV_ENABLE_I;
      DETECT_LEVEL  <= (LV_LEVEL_I == LEVEL_MEDIUM) ? LEVEL_MEDIUM :
                       (LV_LEVEL_I == LEVEL_LOW) ? LEVEL_LOW : LEVEL_HIGH;
    end
  end

endmodule

// file: shared/rssm_pkg.sv
package rssm_pkg;

  localparam int unsigned CLK_MHZ = 250;

  localparam int unsigned CNT_W = 13;

  localparam logic [7:0] INTEG_OFFSET = 8'h00;
  localparam logic [7:0] INTEG_RESET  = 8'h60;

  localparam int unsigned BIT_FAST_PLL_LOCKED = 7;
  localparam int unsigned BIT_TRIM_HIGH       = 6;
  localparam int unsigned BIT_TRIM_LOW        = 5;
  localparam int unsigned BIT_WDG_RESET_FLAG  = 4;
  localparam int unsigned BIT_PLL_LOCKED      = 3;
  localparam int unsigned BIT_LV_RESET_FLAG   = 2;
  localparam int unsigned BIT_AUX_FLAG        = 1;
  localparam int unsigned BIT_AUX_IRQ_ENABLE  = 0;

  localparam logic [1:0] TRIM_RESET = 2'h3;

  localparam logic [CNT_W-1:0] DELAY_SHORT_CYCLES = 13'h0100;
  localparam logic [CNT_W-1:0] DELAY_LONG_CYCLES  = 13'h1000;
  localparam logic [CNT_W-1:0] FETCH_CYCLES       = 13'h0002;

  localparam logic [15:0] VECTOR_ADDR_LO = 16'hFFFE;
  localparam logic [15:0] VECTOR_ADDR_HI = 16'hFFFF;

  localparam logic [1:0] LEVEL_LOW    = 2'h0;
  localparam logic [1:0] LEVEL_MEDIUM = 2'h1;
  localparam logic [1:0] LEVEL_HIGH   = 2'h2;

  typedef enum logic [2:0] {
    SEQ_ACTIVE,
    SEQ_DELAY,
    SEQ_PLL_WAIT,
    SEQ_FETCH,
    SEQ_RUN
  } rssm_state_t;

endpackage

// file: hw/rssm_pin_sync.sv
`timescale 1ns/1ps
module rssm_pin_sync
  import rssm_pkg::*;
(
  // Clock and asynchronous clear
  input  wire logic clk,
  input  wire logic clr_n,
  // Synchronised level
  output logic      level
);

  logic stage1;

  // The clear acts without the clock so a low pin is caught while halted.
  // Release passes two flops before anyone looks at it.
  always_ff @(posedge clk or negedge clr_n) begin
    if (!clr_n) begin
      stage1 <= 1'b0;
      level  <= 1'b0;
    end else begin
      stage1 <= 1'b1;
      level  <= stage1;
    end
  end

endmodule

// file: hw/rssm_phase_timer.sv
`timescale 1ns/1ps
module rssm_phase_timer
  import rssm_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_W
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Load
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  // Status
  output logic                  done
);

  logic [WIDTH-1:0] count;

  generate
    if (WIDTH < CNT_W) begin : g_width_check
      $error("rssm_phase_timer: WIDTH too small for the longest phase");
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (load) begin
      count <= load_value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign done = (count == '0);

endmodule

// file: verif/rssm_ext_reset.sv
`timescale 1ns/1ps
module rssm_ext_reset (
  // Device side of the pin
  input  wire logic pin_o,
  input  wire logic pin_oe,
  // Outside circuitry
  input  wire logic pull_low,
  // Resolved wire
  output logic      pin
);
  // The weak pull-up only wins when nobody sinks the line.
  assign pin = ((pin_oe && !pin_o) || pull_low) ? 1'b0 : 1'b1;
endmodule

// file: verif/rssm_top_props.sv
`timescale 1ns/1ps
module rssm_top_props (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RSTN,
  // Inputs
  input wire logic        WDG_UNDERFLOW_I,
  input wire logic        ILLEGAL_OPCODE_I,
  input wire logic        LV_BELOW_I,
  input wire logic        LV_ENABLE_I,
  input wire logic        HALT_MODE_I,
  input wire logic        CORE_IRQ_MASK_I,
  // Outputs
  input wire logic        RESET_PIN_O,
  input wire logic        RESET_PIN_OE,
  input wire logic        CORE_RESET_N,
  input wire logic        VECTOR_FETCH,
  input wire logic [15:0] VECTOR_ADDR,
  input wire logic        AUX_IRQ,
  input wire logic        WAKE_REQ,
  input wire logic        DETECT_ENABLE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  // Counts how long the device has driven the pin low without a break, so the short delay is checked at its end.
  logic [12:0] low_run;
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      low_run <= 13'h0000;
    end else if (!RESET_PIN_OE) begin
      low_run <= 13'h0000;
    end else if (low_run != 13'h1FFF) begin
      low_run <= low_run + 13'h0001;
    end
  end
  pin_open_drain_a: assert property (RESET_PIN_O == 1'b0)
    else $error("reset pin output driven high");
  pin_low_delay_a: assert property ($rose(VECTOR_FETCH) |-> low_run >= rssm_pkg::DELAY_SHORT_CYCLES)
    else $error("reset pin not held low through the delay");
  fetch_order_a: assert property ($rose(VECTOR_FETCH) |-> VECTOR_ADDR == 16'hFFFE
    ##1 VECTOR_FETCH && VECTOR_ADDR == 16'hFFFF ##1 !VECTOR_FETCH && CORE_RESET_N) else $error("bad vector fetch");
  wdg_start_a: assert property (WDG_UNDERFLOW_I && CORE_RESET_N |=> !CORE_RESET_N)
    else $error("watchdog did not start reset");
  wdg_pulse_a: assert property (WDG_UNDERFLOW_I && CORE_RESET_N |=> RESET_PIN_OE [*8])
    else $error("watchdog pin pulse too short");
  illegal_start_a: assert property (ILLEGAL_OPCODE_I && CORE_RESET_N |=> !CORE_RESET_N && RESET_PIN_OE)
    else $error("illegal opcode did not start reset");
  lv_hold_a: assert property (LV_ENABLE_I && LV_BELOW_I |=> RESET_PIN_OE && !CORE_RESET_N)
    else $error("low supply did not hold reset");
  irq_mask_a: assert property (CORE_IRQ_MASK_I || HALT_MODE_I |=> !AUX_IRQ)
    else $error("aux interrupt while masked");
  halt_wake_a: assert property (HALT_MODE_I |=> !WAKE_REQ)
    else $error("wake request in halt");
  detect_copy_a: assert property ($past(RSTN) |-> DETECT_ENABLE == $past(LV_ENABLE_I))
    else $error("detector enable not following option");
  cover property ($rose(VECTOR_FETCH));
  cover property ($rose(AUX_IRQ));
  cover property ($rose(WAKE_REQ));
endmodule
bind rssm_top rssm_top_props u_props (.MCLK, .RSTN, .WDG_UNDERFLOW_I, .ILLEGAL_OPCODE_I, .LV_BELOW_I, .LV_ENABLE_I,
  .HALT_MODE_I, .CORE_IRQ_MASK_I, .RESET_PIN_O, .RESET_PIN_OE, .CORE_RESET_N, .VECTOR_FETCH, .VECTOR_ADDR, .AUX_IRQ,
  .WAKE_REQ, .DETECT_ENABLE);

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic        mclk, rstn, cyc, stb, we, pull_low, lv_below, wdg, illegal, lv_en, xtal, pll_en;
  logic        aux_below, pll_lk, fpll_lk, halt, waitm, mask, entry;
  logic [1:0]  lvl;
  logic [7:0]  adr;
  logic [7:0]  q;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack, pin, pin_o, pin_oe, core_rst_n, vfetch, airq, wake, det_en;
  logic [15:0] vaddr;
  logic [1:0]  det_lvl;
  int          bad_count, compares, i, m;
  int          n [4];

  rssm_top dut (.MCLK(mclk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .RESET_PIN_I(pin), .RESET_PIN_O(pin_o),
    .RESET_PIN_OE(pin_oe), .LV_BELOW_I(lv_below), .WDG_UNDERFLOW_I(wdg), .ILLEGAL_OPCODE_I(illegal),
    .LV_ENABLE_I(lv_en), .LV_LEVEL_I(lvl), .CLK_SRC_CRYSTAL_I(xtal), .PLL_ENABLE_I(pll_en), .AUX_BELOW_I(aux_below),
    .PLL_LOCKED_I(pll_lk), .FAST_PLL_LOCKED_I(fpll_lk), .HALT_MODE_I(halt), .WAIT_MODE_I(waitm),
    .CORE_IRQ_MASK_I(mask), .AUX_IRQ_ENTRY_I(entry), .CORE_RESET_N(core_rst_n), .VECTOR_FETCH(vfetch),
    .VECTOR_ADDR(vaddr), .AUX_IRQ(airq), .WAKE_REQ(wake), .DETECT_ENABLE(det_en), .DETECT_LEVEL(det_lvl));
  rssm_ext_reset u_ext (.pin_o(pin_o), .pin_oe(pin_oe), .pull_low(pull_low), .pin(pin));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    wb(1'b0, a, 8'h00);
    chk(what, exp, q);
  endtask

  // Source 0 is the watchdog, 1 the illegal opcode; both are one-cycle pulses.
  task automatic pulse(input int src);
    @(posedge mclk);
    if (src == 0) wdg <= 1'b1;
    else illegal <= 1'b1;
    @(posedge mclk);
    wdg <= 1'b0;
    illegal <= 1'b0;
  endtask

  // The first edge lets the launching request land before core reset is polled.
  task automatic run_wait(output int cnt);
    cnt = 0;
    @(posedge mclk);
    while (core_rst_n !== 1'b1) begin
      @(posedge mclk);
      cnt++;
    end
  endtask

  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    {rstn, cyc, stb, we, adr, wdat, pull_low, lv_below, wdg, illegal, lv_en, lvl, xtal, pll_en} = '0;
    {aux_below, pll_lk, fpll_lk, halt, waitm, mask, entry} = '0;
    bad_count = 0;
    compares = 0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    run_wait(m);
    rd(8'h00, 8'h60, "reset value");
    rd(8'h04, 8'h00, "unmapped read");
    pll_lk <= 1'b1;
    fpll_lk <= 1'b1;
    rd(8'h00, 8'he8, "lock bits");
    pll_lk <= 1'b0;
    fpll_lk <= 1'b0;
    for (i = 0; i < 4; i++) begin
      xtal <= (i == 1);
      pll_en <= (i == 2);
      pulse(i / 3);
      run_wait(n[i]);
      rd(8'h00, 8'h70, "watchdog flag");
    end
    chk("crystal delay", rssm_pkg::DELAY_LONG_CYCLES - rssm_pkg::DELAY_SHORT_CYCLES, n[1] - n[0]);
    chk("pll wait", 1000 * rssm_pkg::CLK_MHZ / 1000, n[2] - n[0]);
    chk("illegal opcode run", n[0], n[3]);
    wb(1'b1, 8'h00, 8'h61);
    rd(8'h00, 8'h61, "flag write zero");
    pulse(0);
    run_wait(m);
    lv_en <= 1'b1;
    lv_below <= 1'b1;
    repeat (5) @(posedge mclk);
    lv_below <= 1'b0;
    run_wait(m);
    pull_low <= 1'b1;
    repeat (8) @(posedge mclk);
    pull_low <= 1'b0;
    run_wait(m);
    chk("pin reset ran", 1, m > 256);
    rd(8'h00, 8'h64, "flags after supply and pin reset");
    rd(8'h00, 8'h60, "supply flag read clear");
    for (i = 0; i < 4; i++) begin
      lvl <= i[1:0];
      repeat (2) @(posedge mclk);
      chk("detect level", (i == 3) ? 2 : i, det_lvl);
    end
    wb(1'b1, 8'h00, 8'h61);
    aux_below <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("aux irq", 1, airq);
    rd(8'h00, 8'h63, "aux flag live");
    mask <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("masked irq", 0, airq);
    mask <= 1'b0;
    waitm <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("wake in wait", 1, wake);
    halt <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("no wake in halt", 0, wake);
    wb(1'b1, 8'h00, 8'h00);
    halt <= 1'b0;
    rd(8'h00, 8'h63, "frozen in halt");
    entry <= 1'b1;
    @(posedge mclk);
    entry <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("cleared on entry", 0, airq);
    waitm <= 1'b0;
    lv_en <= 1'b0;
    aux_below <= 1'b0;
    repeat (2) @(posedge mclk);
    aux_below <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("aux off without detector", 0, airq);
    end_of_test;
  end

  // The whole run needs well under ten thousand cycles.
  initial begin
    repeat (40000) @(posedge mclk);
    bad_count++;
    end_of_test;
  end
endmodule
